// ### hdl/ctm_pkg.sv
package ctm_pkg;
    localparam logic [3:0] ctl0_off        = 4'h0;
    localparam logic [3:0] ctl1_off        = 4'h4;
    localparam logic [3:0] cnt_low_off     = 4'h8;
    localparam logic [3:0] cnt_high_off    = 4'hc;
    localparam logic [4:0] match_low_off   = 5'h10;
    localparam logic [4:0] match_high_off  = 5'h14;
    localparam logic [4:0] addr_max        = 5'h14;
    localparam logic [7:0] ctl0_reset      = 8'h00;
    localparam logic [7:0] ctl1_reset      = 8'h00;
    localparam logic [9:0] match_reset     = 10'h000;
    localparam int pause_bit    = 7;
    localparam int clk_sel_lsb  = 4;
    localparam int on_bit       = 3;
    localparam int period_lsb   = 0;
    localparam int mode_lsb     = 6;
    localparam int func_lsb     = 4;
    localparam int init_bit     = 3;
    localparam int invert_bit   = 2;
    localparam int swap_bit     = 1;
    localparam int clr_sel_bit  = 0;
    localparam int high_div_16  = 16;
    localparam int high_div_64  = 64;
    localparam int sys_div_4    = 4;
    typedef enum logic [2:0] {
        ctm_src_sys4, ctm_src_sys, ctm_src_h16, ctm_src_h64,
        ctm_src_tbc, ctm_src_none, ctm_src_rise, ctm_src_fall
    } ctm_src_type;
    typedef enum logic [1:0] {
        ctm_mode_compare, ctm_mode_undef, ctm_mode_pwm, ctm_mode_timer
    } ctm_mode_type;
endpackage

// ### hdl/ctm_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - High bytes accessed directly; low bytes go through one shared 8-bit holding buffer.
// - Match low write only fills the buffer; software writes low then high.
// - Match high write stores high byte and copies buffer into match low byte.
// - High-byte read returns high byte and captures paired low byte into buffer.
// - Low-byte read returns the buffer, not the live low byte.
// - Ten-bit up counter advanced by the selected clock source.
// - Period value compares counter bits 9..7; match value compares all ten bits.
// - Counter cannot be loaded; apart from overflow and match clearing, only the on bit rising edge clears it.
// - Counter clears on overflow or selected comparator match; a match clear raises an event, an overflow only at period 0 with clear select 0.
// - Counter pair is read-only; match pair is read-write.
// - Pause bit holds the counter; clearing it resumes from the held value.
// - Clock select picks sys/4, sys, high/16, high/64, time base, pin edges.
// - Clock select code 101 connects no clock.
// - Clearing on bit stops and keeps value; rising edge clears counter.
// - In compare mode, on bit rising edge restores output to initial level.
// - Period N gives match every N*128 clocks; zero means 1024 clocks.
// - Period match clears the counter when the clear select bit is 0.
// - Two output pins carry the same signal or its inverse.
// - Unused bits 7..2 of counter high and match high read zero.
// - Three modes: compare match output, timer/counter, and a PWM code that only holds the output level.
// - Mode field 00 compare, 10 PWM, 11 timer/counter, 01 undefined.
// - Clear select 0 uses the period match, 1 uses the ten-bit match.
module ctm_timer #(
    parameter int cnt_width = 10
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        time_base_clock,
    input  wire logic        ext_clock_pin,
    input  wire logic        pin_b_invert,
    output logic             timer_out_pin_a,
    output logic             timer_out_pin_b,
    output logic             match_event,
    output logic             period_event
);
    logic [7:0]           ctl0_reg;
    logic [7:0]           ctl1_reg;
    logic [cnt_width-1:0] count_reg;
    logic [cnt_width-1:0] count_next;
    logic [cnt_width-1:0] match_reg;
    logic [7:0]           buffer_reg;
    logic                 on_prev_reg;
    logic [5:0]           div_reg;
    logic                 ext_s1_reg;
    logic                 ext_s2_reg;
    logic                 ext_s3_reg;
    logic                 tbc_s1_reg;
    logic                 tbc_s2_reg;
    logic                 tbc_s3_reg;
    logic                 out_reg;
    logic                 out_next;

    wire                       req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire                       mapped   = (wb_adr_i[1:0] == 2'b00)
                                          && (wb_adr_i <= ctm_pkg::addr_max);
    wire                       wr_lane  = wb_we_i && wb_sel_i[0];
    wire                       acc      = req && mapped;
    wire                       wr_ctl0  = acc && wr_lane
                                          && (wb_adr_i == {1'b0, ctm_pkg::ctl0_off});
    wire                       wr_ctl1  = acc && wr_lane
                                          && (wb_adr_i == {1'b0, ctm_pkg::ctl1_off});
    wire                       wr_mlow  = acc && wr_lane && (wb_adr_i == ctm_pkg::match_low_off);
    wire                       wr_mhigh = acc && wr_lane && (wb_adr_i == ctm_pkg::match_high_off);
    wire                       rd_chigh = acc && !wb_we_i
                                          && (wb_adr_i == {1'b0, ctm_pkg::cnt_high_off});
    wire                       rd_mhigh = acc && !wb_we_i && (wb_adr_i == ctm_pkg::match_high_off);
    wire                       pause    = ctl0_reg[ctm_pkg::pause_bit];
    wire                       on_bit   = ctl0_reg[ctm_pkg::on_bit];
    wire [2:0]                 period   = ctl0_reg[ctm_pkg::period_lsb +: 3];
    wire ctm_pkg::ctm_src_type src      =
        ctm_pkg::ctm_src_type'(ctl0_reg[ctm_pkg::clk_sel_lsb +: 3]);
    wire ctm_pkg::ctm_mode_type mode    =
        ctm_pkg::ctm_mode_type'(ctl1_reg[ctm_pkg::mode_lsb +: 2]);
    wire [1:0]                 func     = ctl1_reg[ctm_pkg::func_lsb +: 2];
    wire                       init_lvl = ctl1_reg[ctm_pkg::init_bit];
    wire                       invert   = ctl1_reg[ctm_pkg::invert_bit];
    wire                       clr_sel  = ctl1_reg[ctm_pkg::clr_sel_bit];
    wire                       on_rise  = on_bit && !on_prev_reg;
    // Edge pulses of the synchronised external and time base clocks
    wire                       ext_rise = ext_s2_reg && !ext_s3_reg;
    wire                       ext_fall = !ext_s2_reg && ext_s3_reg;
    wire                       tbc_rise = tbc_s2_reg && !tbc_s3_reg;
    // Free-running divider taps; the high clock is taken to be the core clock
    wire                       tick_s4  = (div_reg[1:0] == 2'b11);
    wire                       tick_h16 = (div_reg[3:0] == 4'hf);
    wire                       tick_h64 = (div_reg == 6'h3f);
    logic                      tick;

    always_comb begin
        unique case (src)
            ctm_pkg::ctm_src_sys4: tick = tick_s4;
            ctm_pkg::ctm_src_sys:  tick = 1'b1;
            ctm_pkg::ctm_src_h16:  tick = tick_h16;
            ctm_pkg::ctm_src_h64:  tick = tick_h64;
            ctm_pkg::ctm_src_tbc:  tick = tbc_rise;
            ctm_pkg::ctm_src_none: tick = 1'b0;
            ctm_pkg::ctm_src_rise: tick = ext_rise;
            ctm_pkg::ctm_src_fall: tick = ext_fall;
        endcase
    end

    wire advance = on_bit && !pause && tick;
    // Match value is seen while the counter holds it; the period match fires
    // on the tick that would carry the counter to N*128, so a period spans N*128 ticks
    wire p_hit   = advance && (period != 3'b000)
                   && (count_reg[cnt_width-1 -: 3] == period - 3'b001)
                   && (&count_reg[cnt_width-4:0]);
    wire a_hit   = advance && (count_reg == match_reg) && (match_reg != '0);
    wire ovf     = advance && (count_reg == '1);
    wire clr_hit = clr_sel ? (a_hit || ovf) : (p_hit || ovf);

    always_comb begin
        count_next = count_reg;
        if (on_rise) begin
            count_next = '0;
        end else if (clr_hit) begin
            count_next = '0;
        end else if (advance) begin
            count_next = count_reg + 1'b1;
        end
    end

    always_comb begin
        out_next = out_reg;
        if (on_rise && mode == ctm_pkg::ctm_mode_compare) begin
            out_next = init_lvl;
        end else if (a_hit && mode == ctm_pkg::ctm_mode_compare) begin
            unique case (func)
                2'b00: out_next = out_reg;
                2'b01: out_next = 1'b0;
                2'b10: out_next = 1'b1;
                2'b11: out_next = !out_reg;
            endcase
        end
    end

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (wb_adr_i)
            {1'b0, ctm_pkg::ctl0_off}:     rd_byte = ctl0_reg;
            {1'b0, ctm_pkg::ctl1_off}:     rd_byte = ctl1_reg;
            {1'b0, ctm_pkg::cnt_low_off}:  rd_byte = buffer_reg;
            {1'b0, ctm_pkg::cnt_high_off}: rd_byte = {6'h00, count_reg[9:8]};
            ctm_pkg::match_low_off:        rd_byte = buffer_reg;
            ctm_pkg::match_high_off:       rd_byte = {6'h00, match_reg[9:8]};
            default:                       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc;
            wb_err_o <= req && !mapped;
            wb_dat_o <= (acc && !wb_we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl0_reg <= ctm_pkg::ctl0_reset;
            ctl1_reg <= ctm_pkg::ctl1_reset;
        end else begin
            if (wr_ctl0) ctl0_reg <= wb_dat_i[7:0];
            if (wr_ctl1) ctl1_reg <= wb_dat_i[7:0];
        end
    end

    // Counter writes are ignored: the counter pair is read-only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            match_reg  <= ctm_pkg::match_reset;
            buffer_reg <= 8'h00;
        end else begin
            if (wr_mlow) begin
                buffer_reg <= wb_dat_i[7:0];
            end else if (rd_chigh) begin
                buffer_reg <= count_reg[7:0];
            end else if (rd_mhigh) begin
                buffer_reg <= match_reg[7:0];
            end
            if (wr_mhigh) begin
                match_reg <= {wb_dat_i[1:0], buffer_reg};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg   <= '0;
            on_prev_reg <= 1'b0;
            div_reg     <= 6'h00;
            out_reg     <= 1'b0;
        end else begin
            count_reg   <= count_next;
            on_prev_reg <= on_bit;
            div_reg     <= div_reg + 6'h01;
            out_reg     <= out_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            tbc_s1_reg <= 1'b0;
            tbc_s2_reg <= 1'b0;
            tbc_s3_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_clock_pin;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            tbc_s1_reg <= time_base_clock;
            tbc_s2_reg <= tbc_s1_reg;
            tbc_s3_reg <= tbc_s2_reg;
        end
    end

    // Events: match events on every match whatever the clear select; period events only with clear select 0
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            match_event     <= 1'b0;
            period_event    <= 1'b0;
            timer_out_pin_a <= 1'b0;
            timer_out_pin_b <= 1'b0;
        end else begin
            match_event     <= a_hit;
            period_event    <= !clr_sel && (p_hit || (period == 3'b000 && ovf));
            timer_out_pin_a <= (mode == ctm_pkg::ctm_mode_timer) ? 1'b0 : out_next ^ invert;
            timer_out_pin_b <= (mode == ctm_pkg::ctm_mode_timer) ? 1'b0
                               : out_next ^ invert ^ pin_b_invert;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    on_clear_a: assert property (on_rise |=> count_reg == '0)
        else $error("on edge did not clear counter");
    pause_hold_a: assert property (pause && !on_rise |=> $stable(count_reg))
        else $error("paused counter moved");
    none_src_a: assert property (src == ctm_pkg::ctm_src_none && !on_rise
                                 |=> $stable(count_reg))
        else $error("counter moved with no clock");
    sys_step_a: assert property (advance && !clr_hit && !on_rise
                                 && src == ctm_pkg::ctm_src_sys
                                 |=> count_reg == $past(count_reg) + 1'b1)
        else $error("counter did not step");
    period_clr_a: assert property (p_hit && !clr_sel && !on_rise |=> count_reg == '0)
        else $error("period match did not clear");
    buf_copy_a: assert property (wr_mhigh |=> match_reg[7:0] == $past(buffer_reg))
        else $error("buffer not copied to match low");
    buf_cap_a: assert property (rd_chigh && !wr_mlow
                                |=> buffer_reg == $past(count_reg[7:0]))
        else $error("low byte not captured");
    out_init_a: assert property (on_rise && mode == ctm_pkg::ctm_mode_compare
                                 |=> out_reg == $past(init_lvl))
        else $error("output not reset to initial level");
    high_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    bus_ack_a: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not single cycle");

    // Clearing paths: overflow always clears, then the comparator picked by the select bit
    ovf_clr_a: assert property (ovf && !on_rise |=> count_reg == '0)
        else $error("overflow did not clear counter");
    match_clr_a: assert property (a_hit && clr_sel && !on_rise |=> count_reg == '0)
        else $error("match did not clear counter");
    match_keep_a: assert property (a_hit && !clr_sel && !p_hit && !ovf && !on_rise
                                   |=> count_reg != '0)
        else $error("match cleared counter while period clears");
    period_span_a: assert property (p_hit |-> count_reg == {period, 7'h00} - 1'b1)
        else $error("period match at wrong count");
    match_evt_a: assert property (a_hit |=> match_event)
        else $error("match event missing");
    period_evt_a: assert property (clr_sel |=> !period_event)
        else $error("period event while match clears");

    // The counter moves only on a tick or the on edge, never from the bus
    off_hold_a: assert property (!on_bit |=> $stable(count_reg))
        else $error("stopped counter moved");
    no_load_a: assert property (!on_rise && !advance |=> $stable(count_reg))
        else $error("counter changed without a tick");
    sys4_rate_a: assert property (src == ctm_pkg::ctm_src_sys4 && advance && !wr_ctl0
                                  |=> !advance)
        else $error("divided clock ticked twice in a row");

    // Byte access through the shared holding buffer
    low_write_a: assert property (wr_mlow |=> $stable(match_reg))
        else $error("low write reached match value");
    match_high_a: assert property (wr_mhigh |=> match_reg[9:8] == $past(wb_dat_i[1:0]))
        else $error("match high byte not stored");
    high_read_a: assert property (rd_chigh |=> wb_dat_o[1:0] == $past(count_reg[9:8]))
        else $error("counter high byte misread");
    match_cap_a: assert property (rd_mhigh |=> buffer_reg == $past(match_reg[7:0]))
        else $error("match low byte not captured");
    buf_hold_a: assert property (!wr_mlow && !rd_chigh && !rd_mhigh
                                 |=> $stable(buffer_reg))
        else $error("holding buffer changed by itself");
    low_read_a: assert property (acc && !wb_we_i
                                 && wb_adr_i == {1'b0, ctm_pkg::cnt_low_off}
                                 |=> wb_dat_o[7:0] == $past(buffer_reg))
        else $error("low read did not return buffer");
    lane_skip_a: assert property (acc && wb_we_i && !wb_sel_i[0]
                                  |=> $stable(ctl0_reg) && $stable(ctl1_reg)
                                  && $stable(match_reg))
        else $error("write without lane changed a register");
    err_map_a: assert property (req && !mapped |=> wb_err_o && !wb_ack_o && wb_dat_o == '0)
        else $error("unmapped access not refused");

    // Output pins follow the compare output, paired, and rest low in timer mode
    out_hold_a: assert property (mode == ctm_pkg::ctm_mode_compare && !a_hit && !on_rise
                                 |=> $stable(out_reg))
        else $error("output changed without a match");
    timer_pins_a: assert property (mode == ctm_pkg::ctm_mode_timer
                                   |=> !timer_out_pin_a && !timer_out_pin_b)
        else $error("output pins driven in timer mode");
    pin_pair_a: assert property (mode != ctm_pkg::ctm_mode_timer
                                 |=> timer_out_pin_b == (timer_out_pin_a ^ $past(pin_b_invert)))
        else $error("second pin not paired with first");

    cov_ovf_c: cover property (ovf);
    cov_match_c: cover property (a_hit && clr_sel);
    cov_period_c: cover property (p_hit);
    cov_ext_c: cover property (advance && src == ctm_pkg::ctm_src_fall);
    cov_tbc_c: cover property (advance && src == ctm_pkg::ctm_src_tbc);
endmodule

// ### testbench/ctm_ext_src.sv
`timescale 1ns/1ps
module ctm_ext_src (
    output logic ext_clock_pin
);
    initial ext_clock_pin = 1'b0;
    // Pin rests low between bursts; pulses are slow enough for the synchroniser
    task automatic send(input int n);
        repeat (n) begin
            #100 ext_clock_pin <= 1'b1;
            #100 ext_clock_pin <= 1'b0;
        end
        #250;
    endtask
endmodule

// ### testbench/ctm_timer_tb_top.sv
`timescale 1ns/1ps
module ctm_timer_tb_top;
    localparam logic [4:0] adr_c0 = 5'(ctm_pkg::ctl0_off);
    localparam logic [4:0] adr_c1 = 5'(ctm_pkg::ctl1_off);
    localparam logic [4:0] adr_dl = 5'(ctm_pkg::cnt_low_off);
    localparam logic [4:0] adr_dh = 5'(ctm_pkg::cnt_high_off);
    localparam logic [4:0] adr_al = ctm_pkg::match_low_off;
    localparam logic [4:0] adr_ah = ctm_pkg::match_high_off;
    localparam int         sel_tab [6] = '{1, 0, 2, 3, 1, 4};
    localparam int         per_tab [6] = '{1, 1, 1, 1, 0, 1};
    // A period is N*128 ticks, 1024 for N=0; ticks come every 1, 4, 16, 64 or 8 core cycles
    localparam int         len_tab [6] = '{128, 512, 2048, 8192, 1024, 1024};
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [3:0]  sel = 4'h0;
    logic        lane = 1'b1;
    logic        tbc = 1'b0;
    logic [31:0] rdat;
    logic        ack, err, pin_a, pin_b, mev, pev, ext_pin;
    logic [9:0]  notes [$];
    logic [9:0]  m;
    int          error_cnt = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          mev_cnt = 0;
    int          seed = 32'h903a;

    always #12.5 core_clk = ~core_clk;

    ctm_ext_src i_src (.ext_clock_pin(ext_pin));
    ctm_timer i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .time_base_clock(tbc),
        .ext_clock_pin(ext_pin), .pin_b_invert(1'b1), .timer_out_pin_a(pin_a),
        .timer_out_pin_b(pin_b), .match_event(mev), .period_event(pev));

    task automatic fail(input string s);
        error_cnt++;
        $display("unexpected at %0t: %s", $time, s);
    endtask
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) fail($sformatf("read %h, wanted %h", got, exp));
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) fail($sformatf("flag %b, wanted %b", got, exp));
    endtask
    task automatic cmp_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) fail($sformatf("count %0d, wanted %0d", got, exp));
    endtask
    task automatic end_of_test();
        $display("checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Each request leaves a note: error expected, data checked, data
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       input logic chk, input logic e);
        notes.push_back({e, chk, d});
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        sel <= {3'b000, lane};
        do @(posedge core_clk); while (ack !== 1'b1 && err !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b0, 1'b0);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 1'b1, 1'b0);
    endtask
    task automatic cnt_is(input logic [9:0] v);
        rd(adr_dh, {6'h00, v[9:8]});
        rd(adr_dl, v[7:0]);
    endtask
    task automatic pulses(input int n);
        i_src.send(n);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic interval(input int exp);
        int n;
        n = 0;
        while (pev !== 1'b1 && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pev !== 1'b1 && n < 20000);
        cmp_cnt(n, exp);
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles % 4 == 3)
            tbc <= ~tbc;
        if (mev === 1'b1)
            mev_cnt <= mev_cnt + 1;
        if (ack === 1'b1 || err === 1'b1) begin
            if (notes.size() == 0) begin
                fail("answer without request");
            end else begin
                cmp_bit(err, notes[0][9]);
                if (notes[0][8])
                    cmp_data(rdat, {24'h0, notes[0][7:0]});
                void'(notes.pop_front());
            end
        end
        if (cycles == 60000) begin
            fail("timeout");
            end_of_test();
        end
    end

    initial begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) rd(5'(4 * i), 8'h00);
        bus(1'b0, 5'h02, 8'h00, 1'b0, 1'b1);
        bus(1'b1, 5'h18, 8'h5a, 1'b0, 1'b1);
        m = 10'(8 + {$random(seed)} % 40);
        wr(adr_al, m[7:0]);
        rd(adr_ah, 8'h00);
        rd(adr_al, 8'h00);
        wr(adr_al, m[7:0]);
        wr(adr_ah, {6'($random(seed)), m[9:8]});
        rd(adr_ah, {6'h00, m[9:8]});
        rd(adr_al, m[7:0]);
        wr(adr_dh, 8'($random(seed)));
        cnt_is(10'h000);
        wr(adr_c1, 8'h21);
        lane = 1'b0;
        wr(adr_c1, 8'hc0);
        lane = 1'b1;
        rd(adr_c1, 8'h21);
        wr(adr_c0, 8'h60);
        wr(adr_c0, 8'h68);
        pulses(int'(m));
        cnt_is(m);
        cmp_cnt(mev_cnt, 0);
        pulses(1);
        cnt_is(10'h000);
        cmp_cnt(mev_cnt, 1);
        cmp_bit(pin_a, 1'b1);
        cmp_bit(pin_b, 1'b0);
        wr(adr_c0, 8'he8);
        pulses(5);
        cnt_is(10'h000);
        wr(adr_c0, 8'h68);
        pulses(3);
        cnt_is(10'h003);
        wr(adr_c0, 8'h58);
        pulses(4);
        cnt_is(10'h003);
        wr(adr_c0, 8'h60);
        pulses(2);
        cnt_is(10'h003);
        wr(adr_c0, 8'h68);
        cmp_bit(pin_a, 1'b0);
        cmp_bit(pin_b, 1'b1);
        cnt_is(10'h000);
        wr(adr_c0, 8'h78);
        pulses(6);
        cnt_is(10'h006);
        wr(adr_c1, 8'hc0);
        cmp_bit(pin_b, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wr(adr_c0, 8'(sel_tab[i] << 4 | per_tab[i]));
            wr(adr_c0, 8'(sel_tab[i] << 4 | 8 | per_tab[i]));
            interval(len_tab[i]);
        end
        end_of_test();
    end
endmodule
